// *** bmul_pkg.sv ***
// Package for the byte multiply datapath: opcodes, addressing constants, carrier structs
package bmul_pkg;
	localparam logic [6:0] OPC_MUL_REG     = 7'h01;
	localparam logic [7:0] OPC_MUL_LIT     = 8'h0d;
	localparam logic [7:0] IDX_LIMIT       = 8'h5f;
	localparam logic [7:0] ACCESS_SPLIT    = 8'h60;
	localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
	localparam logic [3:0] ACCESS_SFR_BANK = 4'hf;
	localparam logic [7:0] PROD_RST        = 8'h00;
	localparam logic [1:0] QPH_RST         = 2'h0;

	typedef enum logic [1:0] {BMUL_Q1, BMUL_Q2, BMUL_Q3, BMUL_Q4} bmul_phase_e;

	typedef struct packed {
		logic        rd_en;
		logic [11:0] rd_addr;
	} bmul_fread_s;

	typedef struct packed {
		logic [7:0] product_high;
		logic [7:0] product_low;
	} bmul_prod_s;

	typedef struct packed {
		logic [1:0]  rst_sync;
		bmul_phase_e phase;
		logic        is_reg;
		logic        is_lit;
		logic        bank_access;
		logic [7:0]  operand_addr;
		logic [7:0]  literal;
		logic [7:0]  acc_cap;
		logic [7:0]  mul_b;
		logic [15:0] product;
		bmul_fread_s fread;
		bmul_prod_s  prod;
		logic        prod_we;
		logic        busy;
	} bmul_state_s;
endpackage

// *** bmul_unit.sv ***
// Byte multiply datapath: decodes both multiply forms and writes the product pair
// Functional notes
// - Register form multiplies accumulator by file byte
// - Product high byte and low byte stored
// - Accumulator and source register stay untouched
// - No status flags changed at all
// - Register form opcode upper bits 0000001
// - Selector picks access bank or banked address
// - Extended set, selector 0, low address indexed
// - Literal form multiplies accumulator by literal
module bmul_unit
(
	input  wire logic        mclk,
	input  wire logic        rst_n,
	input  wire logic        clk_en,
	input  wire logic        q1_start,
	input  wire logic [15:0] instr_word,
	input  wire logic [7:0]  accumulator,
	input  wire logic [3:0]  bank_select_register,
	input  wire logic        ext_set_en,
	input  wire logic [11:0] index_base,
	input  wire logic [7:0]  file_rd_data,
	output logic             file_rd_en,
	output logic [11:0]      file_rd_addr,
	output logic [7:0]       product_high,
	output logic [7:0]       product_low,
	output logic             product_we,
	output logic             mul_busy
);
	bmul_pkg::bmul_state_s st_ff;
	bmul_pkg::bmul_state_s nxt_st;
	logic                  rst_ok;
	logic                  dec_is_reg;
	logic                  dec_is_lit;
	logic [11:0]           res_addr;
	logic [8:0][15:0]      pp_sum;

	assign rst_ok = st_ff.rst_sync[1];

	assign dec_is_reg = (instr_word[15:9] == bmul_pkg::OPC_MUL_REG);
	assign dec_is_lit = (instr_word[15:8] == bmul_pkg::OPC_MUL_LIT);

	// Resolved from the latched operand, so only bank_select_register, ext_set_en and index_base are read live in Q2
	bmul_addr_res u_addr_res
	(
		.bank_access          (st_ff.bank_access),
		.operand_addr         (st_ff.operand_addr),
		.bank_select_register (bank_select_register),
		.ext_set_en           (ext_set_en),
		.index_base           (index_base),
		.res_addr             (res_addr)
	);

	// Array multiplier: row i adds the accumulator copy shifted by i when multiplier bit i is set
	assign pp_sum[0] = 16'h0000;
	for (genvar i = 0; i < 8; i++)
	begin : g_row
		bmul_pp_row
		#(
			.W   (8),
			.ROW (i)
		)
		u_row
		(
			.mcand      (st_ff.acc_cap),
			.mplier_bit (st_ff.mul_b[i]),
			.sum_in     (pp_sum[i]),
			.sum_out    (pp_sum[i + 1])
		);
	end


	always_comb
	begin
		nxt_st = st_ff;
		nxt_st.rst_sync = {st_ff.rst_sync[0], 1'b1};
		nxt_st.prod_we = 1'b0;
		nxt_st.fread.rd_en = 1'b0;
		if (!rst_ok)
		begin
			nxt_st.phase = bmul_pkg::BMUL_Q1;
			nxt_st.busy = 1'b0;
		end
		else
		begin
			case (st_ff.phase)
				bmul_pkg::BMUL_Q1:
				begin
					if (q1_start)
					begin
						nxt_st.is_reg = dec_is_reg;
						nxt_st.is_lit = dec_is_lit;
						nxt_st.bank_access = instr_word[8];
						nxt_st.operand_addr = instr_word[7:0];
						nxt_st.literal = instr_word[7:0];
						nxt_st.busy = dec_is_reg || dec_is_lit;
						nxt_st.phase = bmul_pkg::BMUL_Q2;
					end
				end
				bmul_pkg::BMUL_Q2:
				begin
					// Address resolution; the file read is only issued, never a write
					if (st_ff.is_reg)
					begin
						nxt_st.fread.rd_en = 1'b1;
						nxt_st.fread.rd_addr = res_addr;
					end
					nxt_st.acc_cap = accumulator;
					nxt_st.phase = bmul_pkg::BMUL_Q3;
				end
				bmul_pkg::BMUL_Q3:
				begin
					// Read data is valid in the same cycle as the read strobe
					nxt_st.mul_b = st_ff.is_reg ? file_rd_data : st_ff.literal;
					nxt_st.phase = bmul_pkg::BMUL_Q4;
				end
				bmul_pkg::BMUL_Q4:
				begin
					// Unsigned 8x8 has no carry or overflow, so no flag output exists
					nxt_st.product = pp_sum[8];
					if (st_ff.is_reg || st_ff.is_lit)
					begin
						nxt_st.prod.product_high = nxt_st.product[15:8];
						nxt_st.prod.product_low = nxt_st.product[7:0];
						nxt_st.prod_we = 1'b1;
					end
					nxt_st.busy = 1'b0;
					nxt_st.is_reg = 1'b0;
					nxt_st.is_lit = 1'b0;
					nxt_st.phase = bmul_pkg::BMUL_Q1;
				end
				default:
				begin
					// Unreachable with four phases; kept so a corrupted phase returns to idle
					nxt_st.busy = 1'b0;
					nxt_st.phase = bmul_pkg::BMUL_Q1;
				end
			endcase
		end
	end

	// Whole state clears at once; the product pair restarts at its reset value
	always_ff @(posedge mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			st_ff <= '0;
			st_ff.phase <= bmul_pkg::BMUL_Q1;
			st_ff.prod.product_high <= bmul_pkg::PROD_RST;
			st_ff.prod.product_low <= bmul_pkg::PROD_RST;
		end
		else if (clk_en)
		begin
			st_ff <= nxt_st;
		end
	end

	assign file_rd_en = st_ff.fread.rd_en;
	assign file_rd_addr = st_ff.fread.rd_addr;
	assign product_high = st_ff.prod.product_high;
	assign product_low = st_ff.prod.product_low;
	assign product_we = st_ff.prod_we;
	assign mul_busy = st_ff.busy;
endmodule

// Operand address resolution for the register form
module bmul_addr_res
(
	input  wire logic        bank_access,
	input  wire logic [7:0]  operand_addr,
	input  wire logic [3:0]  bank_select_register,
	input  wire logic        ext_set_en,
	input  wire logic [11:0] index_base,
	output logic [11:0]      res_addr
);
	always_comb
	begin
		if (bank_access)
		begin
			res_addr = {bank_select_register, operand_addr};
		end
		else if (ext_set_en && operand_addr <= bmul_pkg::IDX_LIMIT)
		begin
			// The index sum wraps at twelve bits, like the file address space
			res_addr = index_base + {4'h0, operand_addr};
		end
		else if (operand_addr < bmul_pkg::ACCESS_SPLIT)
		begin
			res_addr = {bmul_pkg::ACCESS_LOW_BANK, operand_addr};
		end
		else
		begin
			res_addr = {bmul_pkg::ACCESS_SFR_BANK, operand_addr};
		end
	end
endmodule

// One shift-and-add row of the unsigned array multiplier
module bmul_pp_row
#(
	parameter int W   = 8,
	parameter int ROW = 0
)
(
	input  wire logic [W-1:0]   mcand,
	input  wire logic           mplier_bit,
	input  wire logic [2*W-1:0] sum_in,
	output logic [2*W-1:0]      sum_out
);
	logic [2*W-1:0] wide_mcand;
	logic [2*W-1:0] row_term;

	// Widened before the shift so no multiplicand bit falls off the top
	assign wide_mcand = {{W{1'h0}}, mcand};
	assign row_term = mplier_bit ? (wide_mcand << ROW) : '0;
	// Unsigned partial sums never exceed 2*W bits, so dropping the carry loses nothing
	assign sum_out = sum_in + row_term;
endmodule

// *** bmul_monitor.sv ***
// Port checker for the byte multiply datapath
module bmul_monitor
(
	input wire logic        mclk,
	input wire logic        rst_n,
	input wire logic [15:0] instr_word,
	input wire logic [7:0]  accumulator,
	input wire logic [3:0]  bank_select_register,
	input wire logic        ext_set_en,
	input wire logic [11:0] index_base,
	input wire logic        file_rd_en,
	input wire logic [11:0] file_rd_addr,
	input wire logic [7:0]  product_high,
	input wire logic [7:0]  product_low,
	input wire logic        product_we,
	input wire logic        mul_busy
);
	default clocking @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	// Word history, so back-to-back words never overwrite the one in flight
	logic [79:0] word_ff;
	logic [7:0]  f;
	always_ff @(posedge mclk)
		word_ff <= {word_ff[63:0], instr_word};
	assign f = word_ff[23:16];
	AST_WE_TIME: assert property ($rose(mul_busy) |-> ##3 product_we) else $error("late write");
	AST_WE_PULSE: assert property (product_we |-> !mul_busy ##1 !product_we) else $error("long write");
	AST_RD_WE: assert property (file_rd_en |-> ##2 product_we) else $error("read unused");
	AST_RD_OPC: assert property (file_rd_en |-> word_ff[31:25] == bmul_pkg::OPC_MUL_REG) else $error("bad read");
	AST_BANK: assert property (file_rd_en && word_ff[24] |-> file_rd_addr == {bank_select_register, f})
		else $error("bad bank");
	AST_ACCESS: assert property (file_rd_en && !word_ff[24] && !(ext_set_en && f <= bmul_pkg::IDX_LIMIT) |->
		file_rd_addr == {(f < bmul_pkg::ACCESS_SPLIT) ? bmul_pkg::ACCESS_LOW_BANK : bmul_pkg::ACCESS_SFR_BANK, f})
		else $error("bad access");
	AST_INDEX: assert property (file_rd_en && !word_ff[24] && ext_set_en && f <= bmul_pkg::IDX_LIMIT |->
		file_rd_addr == index_base + f) else $error("bad index");
	AST_HOLD: assert property (!product_we |-> $stable({product_high, product_low})) else $error("moved");
	AST_LIT: assert property (product_we && word_ff[63:56] == bmul_pkg::OPC_MUL_LIT |->
		{product_high, product_low} == accumulator * word_ff[55:48]) else $error("bad product");
endmodule
bind bmul_unit bmul_monitor i_bmul_monitor (.*);

// *** bmul_mem.sv ***
// File memory model; outside a read its data line keeps changing
module bmul_mem
(
	input  wire logic        mclk,
	input  wire logic        file_rd_en,
	input  wire logic [11:0] file_rd_addr,
	output logic [7:0]       file_rd_data
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [7:0] hold_ff = 8'h00;
	always_ff @(posedge mclk)
		hold_ff <= file_rd_en ? file_rd_data : ~hold_ff;
	assign file_rd_data = file_rd_en ? file_rd_addr[7:0] ^ {2{file_rd_addr[11:8]}} : hold_ff;
endmodule

// *** test_byte_multiply_instructions.sv ***
// Testbench running both multiply forms against the memory model
module test_byte_multiply_instructions;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk = 0, rst_n = 0, clk_en = 1, q1_start = 0, ext_set_en = 0, file_rd_en, product_we, mul_busy;
	logic [15:0] instr_word = 16'h0000;
	logic [7:0]  accumulator = 8'h00, file_rd_data, product_high, product_low;
	logic [3:0]  bank_select_register = 4'h5;
	logic [11:0] index_base = 12'hfa8, file_rd_addr;
	int          err_count = 0, cmp_count = 0, cyc_count = 0;
	bmul_unit i_bmul_unit (.*);
	bmul_mem i_bmul_mem (.*);
	initial forever #4 mclk = ~mclk;
	always @(posedge mclk)
		if (++cyc_count == 500)
			final_report(1);
	function automatic logic [15:0] memx(input logic [7:0] acc, input logic [11:0] a);
		return acc * (a[7:0] ^ {a[11:8], a[11:8]});
	endfunction
	task automatic final_report(input int hang);
		err_count += hang;
		$display("mismatches %0d compares %0d", err_count, cmp_count);
		if (err_count == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	// Period of eight edges; the phase waits in Q1 for q1_start, so each word lands on a Q1 edge
	task automatic check_mul(input logic [15:0] w, input logic [7:0] acc, input logic we, input logic [15:0] exp);
		q1_start = 1;
		instr_word = w;
		accumulator = acc;
		@(posedge mclk) #1 q1_start = 0;
		instr_word = 16'h0000;
		repeat (3) @(posedge mclk);
		#1 cmp_count++;
		if ({product_we, product_high, product_low} !== {we, exp})
		begin
			err_count++;
			$display("unexpected at %0t: %h %h", $time, {product_we, product_high, product_low}, {we, exp});
		end
		repeat (4) @(posedge mclk);
		#1;
	endtask
	task automatic lit_cases;
		check_mul(16'h0dc4, 8'he2, 1, 16'had08);
		check_mul(16'h0d00, 8'h9b, 1, 16'h0000);
		check_mul(16'h0dff, 8'hff, 1, 16'hfe01);
	endtask
	task automatic reg_cases;
		check_mul(16'h03b5, 8'hc4, 1, memx(8'hc4, 12'h5b5));
		check_mul(16'h025f, 8'h3a, 1, memx(8'h3a, 12'h05f));
		check_mul(16'h0260, 8'h81, 1, memx(8'h81, 12'hf60));
		ext_set_en = 1;
		check_mul(16'h025f, 8'hd7, 1, memx(8'hd7, 12'h007));
		check_mul(16'h0260, 8'h66, 1, memx(8'h66, 12'hf60));
		check_mul(16'h035f, 8'hf1, 1, memx(8'hf1, 12'h55f));
		check_mul(16'h0460, 8'h12, 0, memx(8'hf1, 12'h55f));
	endtask
	initial
	begin
		repeat (8) @(posedge mclk);
		#1 rst_n = 1;
		repeat (3) @(posedge mclk);
		#1 lit_cases();
		reg_cases();
		final_report(0);
	end
endmodule
